// ---- verilog/pcl_loader.v ----
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pcl_map.vh"

// What this block does
// - 8-bit: ratio 1, or 2 with compression
// - 16-bit: ratio 1, 2 encrypted, 4 compressed
// - Load-complete low within 600 ns of request
// - Ready low within 600 ns of request
// - Ready low between 268 and 1506 us
// - Ready rises within 1506 us after request
// - Words sampled on configuration clock rising edges
// - Oscillator init: user mode 175 to 437 us
// - User clock enabled after 4 clock periods
// - Count 8576 init clocks before user mode
// - External low ready or long request postpones
module pcl_loader #(
  parameter STATUS_MIN_CYC = (`PCL_T_STATUS_MIN_US * 1000 + `PCL_CLK_NS - 1) / `PCL_CLK_NS,
  parameter INIT_OSC_CYC = (`PCL_T_CD2UM_MIN_US * 1000 + `PCL_CLK_NS - 1) / `PCL_CLK_NS,
  parameter INIT_USR_CYC = `PCL_T_INIT_CYCLES
) (
  input wire clk,
  input wire nrst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire reconfig_request_low,
  input wire device_ready_low_i,
  output reg device_ready_low_o,
  output reg device_ready_low_oe,
  output reg load_complete,
  input wire cfg_word_clock,
  input wire [15:0] cfg_data,
  input wire user_init_clock,
  output reg user_init_enable,
  output reg user_mode
);

  // ***********************************************
  // States and helpers
  // ***********************************************
  localparam [2:0] ST_CLEAR = 3'h0;
  localparam [2:0] ST_RELEASE = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_INIT_DLY = 3'h3;
  localparam [2:0] ST_INIT = 3'h4;
  localparam [2:0] ST_USER = 3'h5;

  // Last tick of the user clock enable delay, sized to the timer
  localparam CU_CYC = `PCL_CD2CU_CYC;
  localparam [17:0] CU_LAST = CU_CYC[17:0] - 18'h00001;

  function [2:0] ratio_of;
    input w16;
    input enc;
    input cmp;
    begin
      if (!w16) begin
        ratio_of = cmp ? 3'h2 : 3'h1;
      end else if (cmp) begin
        ratio_of = 3'h4;
      end else begin
        ratio_of = enc ? 3'h2 : 3'h1;
      end
    end
  endfunction

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  reg req_s1_q;
  reg req_s2_q;
  reg rdy_s1_q;
  reg rdy_s2_q;
  reg cck_s1_q;
  reg cck_s2_q;
  reg cck_s3_q;
  reg uck_s1_q;
  reg uck_s2_q;
  reg uck_s3_q;
  reg [15:0] dat_s1_q;
  reg [15:0] dat_s2_q;

  always @(posedge clk) begin
    if (!nrst) begin
      req_s1_q <= 1'b1;
      req_s2_q <= 1'b1;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      cck_s1_q <= 1'b0;
      cck_s2_q <= 1'b0;
      cck_s3_q <= 1'b0;
      uck_s1_q <= 1'b0;
      uck_s2_q <= 1'b0;
      uck_s3_q <= 1'b0;
      dat_s1_q <= 16'h0000;
      dat_s2_q <= 16'h0000;
    end else begin
      req_s1_q <= reconfig_request_low;
      req_s2_q <= req_s1_q;
      rdy_s1_q <= device_ready_low_i;
      rdy_s2_q <= rdy_s1_q;
      cck_s1_q <= cfg_word_clock;
      cck_s2_q <= cck_s1_q;
      cck_s3_q <= cck_s2_q;
      uck_s1_q <= user_init_clock;
      uck_s2_q <= uck_s1_q;
      uck_s3_q <= uck_s2_q;
      // Data travels in step with the clock so both are seen at the same edge
      dat_s1_q <= cfg_data;
      dat_s2_q <= dat_s1_q;
    end
  end

  wire cck_rise = cck_s2_q & ~cck_s3_q;
  wire uck_rise = uck_s2_q & ~uck_s3_q;

  // ***********************************************
  // Registers
  // ***********************************************
  reg [3:0] ctrl_q;
  reg [23:0] words_q;
  reg [23:0] count_q;
  reg [15:0] lastw_q;
  reg [2:0] state_q;
  reg [17:0] tmr_q;
  reg [1:0] phase_q;
  reg dp_wr_q;
  reg [7:0] dp_addr_q;

  wire [2:0] ratio = ratio_of(ctrl_q[`PCL_CTRL_W16], ctrl_q[`PCL_CTRL_ENC], ctrl_q[`PCL_CTRL_CMP]);
  wire [15:0] word_in = ctrl_q[`PCL_CTRL_W16] ? dat_s2_q : {8'h00, dat_s2_q[7:0]};

  // ***********************************************
  // AHB-Lite slave, zero wait states
  // ***********************************************
  wire ap_valid = hsel & htrans[1] & hready;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `PCL_OFS_CTRL: begin
        rd_mux = {28'h0000000, ctrl_q};
      end
      `PCL_OFS_WORDS: begin
        rd_mux = {8'h00, words_q};
      end
      `PCL_OFS_STATUS: begin
        rd_mux[`PCL_ST_STATE_LSB +: 3] = state_q;
        rd_mux[`PCL_ST_RATIO_LSB +: 3] = ratio;
        rd_mux[`PCL_ST_READY] = rdy_s2_q;
        rd_mux[`PCL_ST_DONE] = load_complete;
        rd_mux[`PCL_ST_USER] = user_mode;
        rd_mux[`PCL_ST_REQ] = ~req_s2_q;
      end
      `PCL_OFS_COUNT: begin
        rd_mux = {8'h00, count_q};
      end
      `PCL_OFS_LASTW: begin
        rd_mux = {16'h0000, lastw_q};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
      ctrl_q <= `PCL_CTRL_RST;
      words_q <= `PCL_WORDS_RST;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_wr_q <= ap_valid & hwrite & (hsize == 3'h2);
      dp_addr_q <= haddr[7:0];
      if (ap_valid & ~hwrite) begin
        hrdata <= rd_mux;
      end
      if (dp_wr_q) begin
        case (dp_addr_q)
          `PCL_OFS_CTRL: begin
            ctrl_q <= hwdata[3:0];
          end
          `PCL_OFS_WORDS: begin
            words_q <= hwdata[23:0];
          end
          default: begin
            ctrl_q <= ctrl_q;
          end
        endcase
      end
    end
  end

  // ***********************************************
  // Configuration sequence
  // ***********************************************
  always @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_CLEAR;
      tmr_q <= 18'h00000;
      phase_q <= 2'h0;
      count_q <= 24'h000000;
      lastw_q <= 16'h0000;
      device_ready_low_o <= 1'b0;
      device_ready_low_oe <= 1'b1;
      load_complete <= 1'b0;
      user_init_enable <= 1'b0;
      user_mode <= 1'b0;
    end else if (!req_s2_q) begin
      // Request low wins over every state; reacts three cycles after the pin
      state_q <= ST_CLEAR;
      tmr_q <= 18'h00000;
      phase_q <= 2'h0;
      count_q <= 24'h000000;
      device_ready_low_oe <= 1'b1;
      load_complete <= 1'b0;
      user_init_enable <= 1'b0;
      user_mode <= 1'b0;
    end else begin
      case (state_q)
        ST_CLEAR: begin
          // Minimum low time counted from reset or from the end of the request low pulse
          if (tmr_q >= STATUS_MIN_CYC[17:0] - 18'h00001) begin
            device_ready_low_oe <= 1'b0;
            state_q <= ST_RELEASE;
          end else begin
            tmr_q <= tmr_q + 18'h00001;
          end
        end
        ST_RELEASE: begin
          // An outside low on the ready wire keeps loading off
          if (rdy_s2_q) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (cck_rise) begin
            if (phase_q == 2'h0) begin
              lastw_q <= word_in;
              count_q <= count_q + 24'h000001;
              if (count_q + 24'h000001 >= words_q) begin
                load_complete <= 1'b1;
                tmr_q <= 18'h00000;
                state_q <= ctrl_q[`PCL_CTRL_USRCLK] ? ST_INIT_DLY : ST_INIT;
              end
            end
            // Extra clock edges of one word carry no new data
            if ({1'b0, phase_q} == ratio - 3'h1) begin
              phase_q <= 2'h0;
            end else begin
              phase_q <= phase_q + 2'h1;
            end
          end
        end
        ST_INIT_DLY: begin
          if (tmr_q >= CU_LAST) begin
            user_init_enable <= 1'b1;
            tmr_q <= 18'h00000;
            state_q <= ST_INIT;
          end else begin
            tmr_q <= tmr_q + 18'h00001;
          end
        end
        ST_INIT: begin
          if (ctrl_q[`PCL_CTRL_USRCLK]) begin
            if (uck_rise) begin
              if (tmr_q >= INIT_USR_CYC[17:0] - 18'h00001) begin
                user_mode <= 1'b1;
                state_q <= ST_USER;
              end else begin
                tmr_q <= tmr_q + 18'h00001;
              end
            end
          end else if (tmr_q >= INIT_OSC_CYC[17:0] - 18'h00001) begin
            user_mode <= 1'b1;
            state_q <= ST_USER;
          end else begin
            tmr_q <= tmr_q + 18'h00001;
          end
        end
        ST_USER: begin
          user_mode <= 1'b1;
        end
        default: begin
          state_q <= ST_CLEAR;
        end
      endcase
    end
  end

endmodule // pcl_loader

// ---- include/pcl_map.vh ----
`ifndef PCL_MAP_VH
`define PCL_MAP_VH

// ***********************************************
// Register offsets (byte addresses)
// ***********************************************
`define PCL_OFS_CTRL 8'h00
`define PCL_OFS_WORDS 8'h04
`define PCL_OFS_STATUS 8'h08
`define PCL_OFS_COUNT 8'h0c
`define PCL_OFS_LASTW 8'h10

// ***********************************************
// Control fields and reset values
// ***********************************************
`define PCL_CTRL_W16 0
`define PCL_CTRL_ENC 1
`define PCL_CTRL_CMP 2
`define PCL_CTRL_USRCLK 3
`define PCL_CTRL_RST 4'h0
`define PCL_WORDS_RST 24'h000100

// ***********************************************
// Status fields
// ***********************************************
`define PCL_ST_STATE_LSB 0
`define PCL_ST_RATIO_LSB 4
`define PCL_ST_READY 8
`define PCL_ST_DONE 9
`define PCL_ST_USER 10
`define PCL_ST_REQ 11

// ***********************************************
// Timing
// ***********************************************
`define PCL_CLK_NS 8
`define PCL_T_STATUS_MIN_US 268
`define PCL_T_STATUS_MAX_US 1506
`define PCL_T_CD2UM_MIN_US 175
`define PCL_T_CD2UM_MAX_US 437
`define PCL_CFGCLK_MIN_PERIOD_NS 8
`define PCL_CD2CU_PERIODS 4
`define PCL_T_INIT_CYCLES 8576
`define PCL_CD2CU_CYC ((`PCL_CD2CU_PERIODS * `PCL_CFGCLK_MIN_PERIOD_NS + `PCL_CLK_NS - 1) / `PCL_CLK_NS)

`endif

// ---- bench/pcl_sva.sv ----
`timescale 1ns/1ps
// ****************************************
// Port checker for the loader
// ****************************************
module pcl_sva #(
  parameter STATUS_MIN_CYC = 20
) (
  input wire clk,
  input wire nrst,
  input wire hreadyout,
  input wire hresp,
  input wire reconfig_request_low,
  input wire device_ready_low_oe,
  input wire load_complete,
  input wire user_init_enable,
  input wire user_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [31:0] low_cnt_q;
  always @(posedge clk) begin
    if (!nrst || !device_ready_low_oe) low_cnt_q <= 32'h0;
    else low_cnt_q <= low_cnt_q + 32'h1;
  end
  property p_ready_low; !reconfig_request_low |-> ##[1:75] device_ready_low_oe; endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready not pulled low in time");
  property p_done_low; !reconfig_request_low |-> ##[1:75] !load_complete; endproperty
  a_done_low: assert property (p_done_low) else $error("load complete not cleared in time");
  property p_status_min; $fell(device_ready_low_oe) |-> low_cnt_q >= STATUS_MIN_CYC; endproperty
  a_status_min: assert property (p_status_min) else $error("ready released too early");
  // Bound suits the shortened low time used in the bench
  property p_ready_rel; $rose(reconfig_request_low) |-> ##[1:300] !device_ready_low_oe; endproperty
  a_ready_rel: assert property (p_ready_rel) else $error("ready not released");
  property p_load_gate; device_ready_low_oe |-> !load_complete; endproperty
  a_load_gate: assert property (p_load_gate) else $error("load complete while not ready");
  property p_um_delay; $rose(load_complete) |-> !user_mode [*4]; endproperty
  a_um_delay: assert property (p_um_delay) else $error("user mode too soon");
  property p_um_bound; $rose(load_complete) |-> ##[1:1000] user_mode; endproperty
  a_um_bound: assert property (p_um_bound) else $error("user mode never reached");
  property p_cu_delay; $rose(user_init_enable) |-> $past(load_complete, 4); endproperty
  a_cu_delay: assert property (p_cu_delay) else $error("user clock enabled too soon");
  property p_um_cause;
    $rose(user_mode) |-> load_complete && (!user_init_enable || $past(user_init_enable, 8));
  endproperty
  a_um_cause: assert property (p_um_cause) else $error("user mode without init count");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
endmodule // pcl_sva

bind pcl_loader pcl_sva #(.STATUS_MIN_CYC(STATUS_MIN_CYC)) u_pcl_sva (.clk(clk), .nrst(nrst),
  .hreadyout(hreadyout), .hresp(hresp), .reconfig_request_low(reconfig_request_low),
  .device_ready_low_oe(device_ready_low_oe), .load_complete(load_complete),
  .user_init_enable(user_init_enable), .user_mode(user_mode));

// ---- bench/pcl_host.sv ----
`timescale 1ns/1ps
// ****************************************
// Configuration host model
// ****************************************
module pcl_host (
  input wire clk,
  input wire device_ready_low_o,
  input wire device_ready_low_oe,
  output logic reconfig_request_low,
  output wire device_ready_low_i,
  output logic cfg_word_clock,
  output logic [15:0] cfg_data,
  output logic user_init_clock
);
  logic ext_hold_q;
  // Open-drain wire with pull-up; the host may hold it low to postpone
  assign device_ready_low_i = !(device_ready_low_oe && !device_ready_low_o) && !ext_hold_q;
  initial begin
    ext_hold_q = 1'b0;
    reconfig_request_low = 1'b1;
    cfg_word_clock = 1'b0;
    cfg_data = 16'h0;
    user_init_clock = 1'b0;
  end
  // Toggles only on falling edges of clk so it never races the sampling edge
  always #40 user_init_clock = ~user_init_clock;
  task pulse(input int cyc);
    @(posedge clk) reconfig_request_low <= 1'b0;
    repeat (cyc) @(posedge clk);
    reconfig_request_low <= 1'b1;
  endtask
  // Clock stands still between words; 160 ns period keeps 0.5 duty
  task send(input logic [15:0] w, input int r);
    cfg_data <= w;
    repeat (r) begin
      repeat (10) @(posedge clk);
      cfg_word_clock <= 1'b1;
      repeat (10) @(posedge clk);
      cfg_word_clock <= 1'b0;
    end
    cfg_data <= ~w;
  endtask
endmodule // pcl_host

// ---- bench/test_parallel_config_loader.sv ----
`timescale 1ns/1ps
`include "pcl_map.vh"
module test_parallel_config_loader;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [2:0] sz = 3'h2;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rq_n, rdy_o, rdy_oe, rdy_i, lc, cclk, uclk, uen, um;
  wire [15:0] cdata;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int r;
  logic [31:0] d;
  logic [15:0] w;
  always #4 clk = ~clk;
  pcl_loader #(.STATUS_MIN_CYC(20), .INIT_OSC_CYC(10), .INIT_USR_CYC(5)) u_pcl_loader (.clk(clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reconfig_request_low(rq_n),
    .device_ready_low_i(rdy_i), .device_ready_low_o(rdy_o), .device_ready_low_oe(rdy_oe), .load_complete(lc),
    .cfg_word_clock(cclk), .cfg_data(cdata), .user_init_clock(uclk), .user_init_enable(uen), .user_mode(um));
  pcl_host u_pcl_host (.clk(clk), .device_ready_low_o(rdy_o), .device_ready_low_oe(rdy_oe),
    .reconfig_request_low(rq_n), .device_ready_low_i(rdy_i), .cfg_word_clock(cclk), .cfg_data(cdata),
    .user_init_clock(uclk));
  task ahb(input logic [31:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Guard against a hang anywhere in the sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ****************************************
  // Register defaults, then every width and feature mode
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    ahb(`PCL_OFS_CTRL, 1'b0, 32'h0, d); chk(d, 32'h0);
    ahb(`PCL_OFS_WORDS, 1'b0, 32'h0, d); chk(d, 32'h100);
    ahb(32'h20, 1'b1, 32'hffff_ffff, d);
    ahb(32'h20, 1'b0, 32'h0, d); chk(d, 32'h0);
    // A byte-sized write must leave the register alone
    sz = 3'h0;
    ahb(`PCL_OFS_WORDS, 1'b1, 32'h5, d);
    sz = 3'h2;
    ahb(`PCL_OFS_WORDS, 1'b0, 32'h0, d); chk(d, 32'h100);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      r = m[0] ? (m[2] ? 4 : m[1] ? 2 : 1) : (m[2] ? 2 : 1);
      ahb(`PCL_OFS_CTRL, 1'b1, m | (m == 7 ? 8 : 0), d);
      ahb(`PCL_OFS_WORDS, 1'b1, 32'h2, d);
      if (m == 0) u_pcl_host.ext_hold_q <= 1'b1;
      u_pcl_host.pulse(250);
      if (m == 0) begin
        repeat (100) @(posedge clk);
        ahb(`PCL_OFS_STATUS, 1'b0, 32'h0, d); chk(d[2:0], 32'h1);
        u_pcl_host.ext_hold_q <= 1'b0;
      end
      // Mode 1 stands for a host that ignores the ready wire and waits the worst case
      if (m == 1) repeat (300) @(posedge clk);
      else wait (rdy_i);
      repeat (250) @(posedge clk);
      ahb(`PCL_OFS_STATUS, 1'b0, 32'h0, d); chk(d[6:4], r);
      w = 16'ha5c3 + m[15:0];
      u_pcl_host.send(w, r);
      repeat (10) @(posedge clk);
      chk(lc, 32'h0);
      u_pcl_host.send(w + 16'h1111, r);
      wait (lc);
      ahb(`PCL_OFS_COUNT, 1'b0, 32'h0, d); chk(d, 32'h2);
      ahb(`PCL_OFS_LASTW, 1'b0, 32'h0, d); chk(d, m[0] ? w + 16'h1111 : (w + 16'h1111) & 16'hff);
      wait (um);
      ahb(`PCL_OFS_STATUS, 1'b0, 32'h0, d); chk(d[10:8], 32'h7);
      chk(uen, m == 7);
      $display("test mode %0d done", m);
    end
    conclude();
  end
endmodule // test_parallel_config_loader
